// ==== common/frame_align_pkg.sv ====
// Constants and types shared by the frame alignment pipeline.
package frame_align_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [9:0] MIN_FRAME_CYCLES = 10'h200;
    localparam logic [1:0] FRAME_STAGES = 2'h2;
    typedef enum logic [2:0] {
        WAIT_FIRST = 3'b001,
        WAIT_SECOND = 3'b010,
        RUN = 3'b100
    } align_state_t;
endpackage

// ==== rtl/stream_fifo.sv ====
// Parameterised valid/ready FIFO held in flip-flops.
`timescale 1ns/10ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = cnt_reg < (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem_reg[rd_reg];
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== rtl/frame_align.sv ====
// Frame alignment and two-frame latency pipeline for the serial transcoder ports.
// Behaviour
// - Each input stream is shifted in over a whole frame before that frame's data is used.
// - Frame timing follows the frame pulse in bus mode and the first channel strobe otherwise.
// - A frame is processed during the next frame, so input of frame N leaves in frame N+2.
// - Signalling, control and bypass data see the same two-frame latency as coded data.
// - Input bits are taken on the bit clock falling edge and output changes on its rising edge.
`timescale 1ns/10ps
module frame_align
    import frame_align_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Mode and timing inputs.
    input wire logic tdm_bus_mode,
    input wire logic frame_pulse_in,
    input wire logic first_channel_strobe,
    input wire logic second_channel_strobe,
    input wire logic bit_clk,
    // Serial data.
    input wire logic serial_in,
    output logic serial_out,
    // Alignment status.
    output logic frame_start,
    output logic order_error
);
    logic [2:0] fp_sync_reg;
    logic [2:0] s1_sync_reg;
    logic [2:0] s2_sync_reg;
    logic [2:0] bc_sync_reg;
    logic [2:0] di_sync_reg;
    logic fp_reg;
    logic s1_reg;
    logic s2_reg;
    logic bc_reg;
    logic di_reg;
    logic frame_edge;
    logic s1_rise;
    logic s2_rise;
    logic bc_fall;
    logic bc_rise;
    logic [DATA_W-1:0] in_shift_reg;
    logic [2:0] bit_cnt_reg;
    logic word_done;
    logic [DATA_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_in_ready;
    logic [DATA_W-1:0] proc_reg;
    logic [DATA_W-1:0] out_shift_reg;
    logic [1:0] fill_reg;
    logic proc_valid_reg;
    logic out_valid_reg;
    logic serial_out_reg;
    logic frame_start_reg;
    logic order_error_reg;
    align_state_t state_reg;
    logic [9:0] gap_cnt_reg;
    // Three-stage synchronisers; a change counts once stages two and three agree.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fp_sync_reg <= 3'h0;
            s1_sync_reg <= 3'h0;
            s2_sync_reg <= 3'h0;
            bc_sync_reg <= 3'h0;
            di_sync_reg <= 3'h0;
        end else begin
            fp_sync_reg <= {fp_sync_reg[1:0], frame_pulse_in};
            s1_sync_reg <= {s1_sync_reg[1:0], first_channel_strobe};
            s2_sync_reg <= {s2_sync_reg[1:0], second_channel_strobe};
            bc_sync_reg <= {bc_sync_reg[1:0], bit_clk};
            di_sync_reg <= {di_sync_reg[1:0], serial_in};
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fp_reg <= 1'b0;
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            bc_reg <= 1'b0;
            di_reg <= 1'b0;
        end else begin
            if (fp_sync_reg[1] == fp_sync_reg[2]) fp_reg <= fp_sync_reg[2];
            if (s1_sync_reg[1] == s1_sync_reg[2]) s1_reg <= s1_sync_reg[2];
            if (s2_sync_reg[1] == s2_sync_reg[2]) s2_reg <= s2_sync_reg[2];
            if (bc_sync_reg[1] == bc_sync_reg[2]) bc_reg <= bc_sync_reg[2];
            if (di_sync_reg[1] == di_sync_reg[2]) di_reg <= di_sync_reg[2];
        end
    end
    assign s1_rise = (s1_sync_reg[2] == s1_sync_reg[1]) && s1_sync_reg[2] && !s1_reg;
    assign s2_rise = (s2_sync_reg[2] == s2_sync_reg[1]) && s2_sync_reg[2] && !s2_reg;
    assign bc_fall = (bc_sync_reg[2] == bc_sync_reg[1]) && !bc_sync_reg[2] && bc_reg;
    assign bc_rise = (bc_sync_reg[2] == bc_sync_reg[1]) && bc_sync_reg[2] && !bc_reg;
    // Frame boundary from the frame pulse or from the first channel strobe.
    assign frame_edge = tdm_bus_mode
        ? ((fp_sync_reg[2] == fp_sync_reg[1]) && fp_sync_reg[2] && !fp_reg)
        : s1_rise;
    // Strobe order checker flags, outside bus mode, a strobe repeated without the other in between, once a first channel strobe has been seen.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= WAIT_FIRST;
            order_error_reg <= 1'b0;
        end else begin
            case (state_reg)
                WAIT_FIRST: begin
                    if (s1_rise) state_reg <= WAIT_SECOND;
                end
                WAIT_SECOND: begin
                    if (s2_rise) state_reg <= RUN;
                    else if (s1_rise && !tdm_bus_mode) order_error_reg <= 1'b1;
                end
                RUN: begin
                    if (s1_rise) state_reg <= WAIT_SECOND;
                    else if (s2_rise && !tdm_bus_mode) order_error_reg <= 1'b1;
                end
                default: state_reg <= WAIT_FIRST;
            endcase
            if (frame_edge && gap_cnt_reg < MIN_FRAME_CYCLES && fill_reg != 2'h0) begin
                order_error_reg <= 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || frame_edge) begin
            gap_cnt_reg <= 10'h0;
        end else if (gap_cnt_reg != 10'h3ff) begin
            gap_cnt_reg <= gap_cnt_reg + 10'h1;
        end
    end
    // Bits are sampled on the bit clock falling edge into the input register.
    always_ff @(posedge core_clk) begin
        if (rst || frame_edge) begin
            bit_cnt_reg <= BIT_COUNT_RESET;
            in_shift_reg <= '0;
        end else if (bc_fall) begin
            in_shift_reg <= {in_shift_reg[DATA_W-2:0], di_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end
    assign word_done = bc_fall && bit_cnt_reg == BIT_LAST && !frame_edge;
    // Data of a frame is held in the FIFO until the frame has fully arrived.
    stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) i_stream_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(word_done),
        .in_ready(fifo_in_ready),
        .in_data({in_shift_reg[DATA_W-2:0], di_reg}),
        .out_valid(fifo_valid),
        .out_ready(frame_edge),
        .out_data(fifo_data)
    );
    // Frame N moves to the process stage at frame N+1 and to the output at N+2.
    // Every channel kind, bypass included, shares this same path.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            proc_reg <= '0;
            out_shift_reg <= '0;
            proc_valid_reg <= 1'b0;
            out_valid_reg <= 1'b0;
            fill_reg <= 2'h0;
        end else if (frame_edge) begin
            proc_reg <= fifo_valid ? fifo_data : '0;
            proc_valid_reg <= fifo_valid;
            out_shift_reg <= proc_reg;
            out_valid_reg <= proc_valid_reg;
            if (fill_reg != FRAME_STAGES) fill_reg <= fill_reg + 2'h1;
        end else if (bc_rise && out_valid_reg) begin
            out_shift_reg <= {out_shift_reg[DATA_W-2:0], 1'b0};
        end
    end
    // Output bit changes on the bit clock rising edge.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serial_out_reg <= 1'b0;
        end else if (bc_rise) begin
            serial_out_reg <= out_valid_reg ? out_shift_reg[DATA_W-1] : 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) frame_start_reg <= 1'b0;
        else frame_start_reg <= frame_edge;
    end
    assign serial_out = serial_out_reg;
    assign frame_start = frame_start_reg;
    assign order_error = order_error_reg;
    // Frame alignment pulses stay one cycle wide.
    frame_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        frame_start |=> !frame_start) else $error("frame start longer than one cycle");
    latency_two_a: assert property (@(posedge core_clk) disable iff (rst)
        frame_edge && proc_valid_reg |=> out_shift_reg == $past(proc_reg))
        else $error("output frame not taken from process stage");
    load_whole_a: assert property (@(posedge core_clk) disable iff (rst)
        frame_edge |=> bit_cnt_reg == 3'h0) else $error("bit count not cleared at frame");
    sample_fall_a: assert property (@(posedge core_clk) disable iff (rst)
        !bc_fall && !frame_edge |=> $stable(bit_cnt_reg))
        else $error("input sampled off falling edge");
    out_rise_a: assert property (@(posedge core_clk) disable iff (rst)
        !bc_rise |=> $stable(serial_out)) else $error("output moved off rising edge");
    bypass_same_a: assert property (@(posedge core_clk) disable iff (rst)
        frame_edge |=> out_valid_reg == $past(proc_valid_reg))
        else $error("latency differs across paths");
    mode_source_a: assert property (@(posedge core_clk) disable iff (rst)
        !tdm_bus_mode && frame_edge |-> s1_rise) else $error("strobe mode frame source");
    proc_load_a: assert property (@(posedge core_clk) disable iff (rst)
        frame_edge && fifo_valid |=> proc_reg == $past(fifo_data))
        else $error("process stage not loaded");
    fifo_room_a: assert property (@(posedge core_clk) disable iff (rst)
        word_done |-> fifo_in_ready) else $error("completed word found no room");
endmodule

// ==== sim/frame_source.sv ====
// Behavioural model of the codec side: frame timing, bit clock and serial data.
`timescale 1ns/10ps
module frame_source (
    // Mode.
    input wire logic tdm_bus_mode,
    // Timing towards the block.
    output logic frame_pulse_in,
    output logic first_channel_strobe,
    output logic second_channel_strobe,
    output logic bit_clk,
    // Serial data.
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        frame_pulse_in = 1'b0;
        first_channel_strobe = 1'b0;
        second_channel_strobe = 1'b0;
        bit_clk = 1'b0;
        serial_in = 1'b0;
    end

    // Sends one frame of len_ns; the bit clock runs only in the first slot.
    task automatic send_frame(input logic [7:0] word, input int len_ns, input bit skip_second,
                              output logic [7:0] rx);
        rx = 8'h00;
        if (tdm_bus_mode)
            frame_pulse_in = 1'b1;
        else
            first_channel_strobe = 1'b1;
        #1000;
        frame_pulse_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            bit_clk = 1'b1;
            serial_in = word[7 - i];
            #400;
            bit_clk = 1'b0;
            #400;
            rx = {rx[6:0], serial_out};
        end
        first_channel_strobe = 1'b0;
        serial_in = ~serial_in;
        #(len_ns / 3 - 7400);
        if (!skip_second)
            second_channel_strobe = 1'b1;
        #7400;
        second_channel_strobe = 1'b0;
        #(len_ns - len_ns / 3 - 7400);
    endtask
endmodule

// ==== sim/test_frame_align.sv ====
// Self-checking bench for the frame alignment pipeline.
`timescale 1ns/10ps
module test_frame_align;
    logic core_clk, rst, tdm_bus_mode, frame_pulse_in, first_channel_strobe;
    logic second_channel_strobe, bit_clk, serial_in, serial_out, frame_start, order_error;
    int errors = 0;
    int samples_checked = 0;
    int starts = 0;

    frame_align i_frame_align (.core_clk(core_clk), .rst(rst), .tdm_bus_mode(tdm_bus_mode),
        .frame_pulse_in(frame_pulse_in), .first_channel_strobe(first_channel_strobe),
        .second_channel_strobe(second_channel_strobe), .bit_clk(bit_clk),
        .serial_in(serial_in), .serial_out(serial_out), .frame_start(frame_start),
        .order_error(order_error));

    frame_source i_frame_source (.tdm_bus_mode(tdm_bus_mode), .frame_pulse_in(frame_pulse_in),
        .first_channel_strobe(first_channel_strobe),
        .second_channel_strobe(second_channel_strobe), .bit_clk(bit_clk),
        .serial_in(serial_in), .serial_out(serial_out));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (frame_start === 1'b1)
            starts <= starts + 1;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic do_reset(input logic mode);
        @(posedge core_clk);
        rst <= 1'b1;
        tdm_bus_mode <= mode;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check("reset outputs", {5'h00, serial_out, frame_start, order_error}, 8'h00);
    endtask

    task automatic run_latency(input logic mode);
        logic [7:0] words [5] = '{8'h96, 8'h3c, 8'ha5, 8'h01, 8'hf0};
        logic [7:0] rx;
        int s0;
        do_reset(mode);
        s0 = starts;
        for (int k = 0; k < 5; k++) begin
            i_frame_source.send_frame(words[k], 60000, 1'b0, rx);
            if (k >= 2)
                check("delayed word", rx, words[k - 2]);
        end
        check("frame starts", 8'(starts - s0), 8'h05);
        check("order flag", {7'h00, order_error}, 8'h00);
    endtask

    task automatic run_order_fault();
        logic [7:0] rx;
        do_reset(1'b0);
        i_frame_source.send_frame(8'h11, 60000, 1'b1, rx);
        i_frame_source.send_frame(8'h22, 60000, 1'b0, rx);
        check("order flag", {7'h00, order_error}, 8'h01);
    endtask

    task automatic run_short_frame();
        logic [7:0] rx;
        do_reset(1'b0);
        for (int k = 0; k < 3; k++)
            i_frame_source.send_frame(8'h5a, 60000, 1'b0, rx);
        check("order flag", {7'h00, order_error}, 8'h00);
        i_frame_source.send_frame(8'h33, 40000, 1'b0, rx);
        i_frame_source.send_frame(8'h44, 60000, 1'b0, rx);
        check("gap flag", {7'h00, order_error}, 8'h01);
    endtask

    initial begin
        #2000000;
        errors++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        tdm_bus_mode = 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        run_latency(1'b0);
        run_latency(1'b1);
        run_order_fault();
        run_short_frame();
        end_of_test();
    end
endmodule
